// File: core/gdcr_defs.vh
// Constants for the pin and datapath configuration register bank.
// Assumes inclusion by bare name from the core folder.
`ifndef GDCR_DEFS_VH
`define GDCR_DEFS_VH
`define GDCR_ADDR_PIN_SETUP   8'h21
`define GDCR_ADDR_PATH_CTRL   8'h22
`define GDCR_RST_PIN_SETUP    8'h00
`define GDCR_RST_PATH_CTRL    8'h00
`define GDCR_BIT_P8_VALUE     7
`define GDCR_BIT_P8_FAR       6
`define GDCR_BIT_P8_DIR       5
`define GDCR_BIT_P8_EN        4
`define GDCR_BIT_P7_VALUE     3
`define GDCR_BIT_P7_FAR       2
`define GDCR_BIT_P7_DIR       1
`define GDCR_BIT_KEEP_LOCAL   7
`define GDCR_BIT_PASSTHRU     6
`define GDCR_BIT_LV_POL       5
`define GDCR_BIT_AUD_BLOCK    4
`define GDCR_BIT_QUAD_OVR     3
`define GDCR_BIT_DEPTH18      2
`define GDCR_BIT_INBAND       1
`define GDCR_BIT_QUAD_EN      0
`define GDCR_MODE_FUNC_OUT    2'b00
`define GDCR_MODE_GP_OUT      2'b01
`define GDCR_MODE_TRISTATE    2'b10
`define GDCR_MODE_GP_IN       2'b11
`define GDCR_RESP_OKAY        2'b00
`define GDCR_RESP_SLVERR      2'b10
`endif

// File: core/gdcr_pin_ctrl.v
// One general-purpose pin's mode decoder and output driver.
// Assumes remote and pad inputs are already synchronised to the core clock.
`timescale 1ns/10ps
`include "gdcr_defs.vh"
module gdcr_pin_ctrl (
   input  wire       local_value_in,
   input  wire       far_drive_in,
   input  wire       direction_in,
   input  wire       enable_in,
   input  wire       remote_value_in,
   input  wire       func_value_in,
   input  wire       func_oe_in,
   output reg        pin_o_out,
   output reg        pin_oe_out,
   output wire [1:0] mode_out
);
   assign mode_out = {direction_in, enable_in};

   always @* begin
      pin_o_out  = 1'b0;
      pin_oe_out = 1'b0;
      if (far_drive_in) begin
         // Remote control wins over every local mode code.
         pin_o_out  = remote_value_in;
         pin_oe_out = 1'b1;
      end else begin
         case (mode_out)
            `GDCR_MODE_FUNC_OUT: begin
               pin_o_out  = func_value_in;
               pin_oe_out = func_oe_in;
            end
            `GDCR_MODE_GP_OUT: begin
               pin_o_out  = local_value_in;
               pin_oe_out = 1'b1;
            end
            `GDCR_MODE_TRISTATE: begin
               pin_oe_out = 1'b0;
            end
            `GDCR_MODE_GP_IN: begin
               pin_oe_out = 1'b0;
            end
            default: begin
               pin_oe_out = 1'b0;
            end
         endcase
      end
   end
endmodule

// File: core/gdcr_top.v
// Pin seven/eight setup and video/audio datapath control registers on AXI4-Lite.
// Assumes a single core clock; pin and far-end inputs are asynchronous.
//
// Summary of operation
// - Local value drives pin only in general-purpose output mode without remote control.
// - Remote-control bit set makes the pin an output carrying far-end value.
// - Mode code 00 functional, 10 tri-state, 01 GP output, 11 GP input; pin seven has its enable tied low, so only 00 and 10.
// - Override bit set blocks forward-channel loading, keeping local values.
// - Bits six to zero load from far end unless override is set.
// - Pass-through forwards pixels regardless of line-valid strobe.
// - Polarity bit one means line-valid active low, zero active high.
// - Block bit set keeps packetized audio off the video pins.
// - Four-channel override set takes enable from bit zero, else forced off.
// - Depth bit one selects 18-bit video, zero selects 24-bit.
// - Transport bit one selects in-band, zero data-island audio.
// - Four-channel enable bit turns four-channel audio on or off.
// - Pin setup register at 21h, resets to zero.
// - Datapath control register at 22h, resets to zero.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "gdcr_defs.vh"
module gdcr_top (
   input  wire        CORE_CLK_IN,
   input  wire        NRST_IN,
   input  wire [7:0]  S_AXI_AWADDR_IN,
   input  wire        S_AXI_AWVALID_IN,
   output wire        S_AXI_AWREADY_OUT,
   input  wire [31:0] S_AXI_WDATA_IN,
   input  wire [3:0]  S_AXI_WSTRB_IN,
   input  wire        S_AXI_WVALID_IN,
   output wire        S_AXI_WREADY_OUT,
   output wire [1:0]  S_AXI_BRESP_OUT,
   output wire        S_AXI_BVALID_OUT,
   input  wire        S_AXI_BREADY_IN,
   input  wire [7:0]  S_AXI_ARADDR_IN,
   input  wire        S_AXI_ARVALID_IN,
   output wire        S_AXI_ARREADY_OUT,
   output wire [31:0] S_AXI_RDATA_OUT,
   output wire [1:0]  S_AXI_RRESP_OUT,
   output wire        S_AXI_RVALID_OUT,
   input  wire        S_AXI_RREADY_IN,
   input  wire        FC_LOAD_IN,
   input  wire [6:0]  FC_PATH_VALUE_IN,
   input  wire        FAR_PIN7_VALUE_IN,
   input  wire        FAR_PIN8_VALUE_IN,
   input  wire        FUNC_PIN7_VALUE_IN,
   input  wire        FUNC_PIN7_OE_IN,
   input  wire        FUNC_PIN8_VALUE_IN,
   input  wire        FUNC_PIN8_OE_IN,
   input  wire        PIN7_IN,
   input  wire        PIN8_IN,
   input  wire        LINE_VALID_STROBE_IN,
   output wire        PIN7_OUT,
   output wire        PIN7_OE_OUT,
   output wire        PIN8_OUT,
   output wire        PIN8_OE_OUT,
   output wire        PIN7_SAMPLE_OUT,
   output wire        PIN8_SAMPLE_OUT,
   output reg         PIXEL_ENABLE_OUT,
   output wire        CONTENT_PROT_ENABLE_OUT,
   output wire        AUDIO_ON_VIDEO_OUT,
   output wire        QUAD_AUDIO_OUT,
   output wire        DEPTH_18BIT_OUT,
   output wire        INBAND_AUDIO_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for asynchronous inputs.

   reg [6:0]  fc_val_m_q;
   reg [6:0]  fc_val_s_q;
   reg [2:0]  fc_ld_q;
   reg [1:0]  far_m_q;
   reg [1:0]  far_s_q;
   reg [1:0]  pin_m_q;
   reg [1:0]  pin_s_q;
   reg        lv_m_q;
   reg        lv_s_q;

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         fc_val_m_q <= 7'h00;
         fc_val_s_q <= 7'h00;
         fc_ld_q    <= 3'h0;
         far_m_q    <= 2'h0;
         far_s_q    <= 2'h0;
         pin_m_q    <= 2'h0;
         pin_s_q    <= 2'h0;
         lv_m_q     <= 1'b0;
         lv_s_q     <= 1'b0;
      end else begin
         fc_val_m_q <= FC_PATH_VALUE_IN;
         fc_val_s_q <= fc_val_m_q;
         fc_ld_q    <= {fc_ld_q[1:0], FC_LOAD_IN};
         far_m_q    <= {FAR_PIN8_VALUE_IN, FAR_PIN7_VALUE_IN};
         far_s_q    <= far_m_q;
         pin_m_q    <= {PIN8_IN, PIN7_IN};
         pin_s_q    <= pin_m_q;
         lv_m_q     <= LINE_VALID_STROBE_IN;
         lv_s_q     <= lv_m_q;
      end
   end

   // Load event on the rising edge of the synchronised load level; the value
   // bus has settled one cycle before, since the source holds it stable.
   wire fc_load_evt = fc_ld_q[1] & ~fc_ld_q[2];

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave: one write and one read at a time.

   reg        aw_got_q;
   reg        w_got_q;
   reg [7:0]  awaddr_q;
   reg [7:0]  wdata_q;
   reg        wstrb0_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        rvalid_q;
   reg [1:0]  rresp_q;
   reg [7:0]  rdata_q;
   reg [7:0]  pin_setup_q;
   reg [7:0]  path_ctrl_q;

   assign S_AXI_AWREADY_OUT = ~aw_got_q & ~bvalid_q;
   assign S_AXI_WREADY_OUT  = ~w_got_q & ~bvalid_q;
   assign S_AXI_ARREADY_OUT = ~rvalid_q;
   assign S_AXI_BVALID_OUT  = bvalid_q;
   assign S_AXI_BRESP_OUT   = bresp_q;
   assign S_AXI_RVALID_OUT  = rvalid_q;
   assign S_AXI_RRESP_OUT   = rresp_q;
   assign S_AXI_RDATA_OUT   = {24'h000000, rdata_q};

   wire aw_hs = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
   wire w_hs  = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
   wire aw_ok = aw_got_q | aw_hs;
   wire w_ok  = w_got_q | w_hs;
   wire [7:0] wa   = aw_got_q ? awaddr_q : S_AXI_AWADDR_IN;
   wire [7:0] wd   = w_got_q ? wdata_q : S_AXI_WDATA_IN[7:0];
   wire       ws0  = w_got_q ? wstrb0_q : S_AXI_WSTRB_IN[0];
   wire       do_w = aw_ok & w_ok & ~bvalid_q;
   // Byte addresses: the 21h and 22h words sit at 84h and 88h.
   wire       w_pin  = ({2'b00, wa[7:2]} == `GDCR_ADDR_PIN_SETUP) & (wa[1:0] == 2'b00);
   wire       w_path = ({2'b00, wa[7:2]} == `GDCR_ADDR_PATH_CTRL) & (wa[1:0] == 2'b00);

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= `GDCR_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awaddr_q <= S_AXI_AWADDR_IN;
         end
         if (w_hs) begin
            wdata_q  <= S_AXI_WDATA_IN[7:0];
            wstrb0_q <= S_AXI_WSTRB_IN[0];
         end
         if (do_w) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= (w_pin | w_path) ? `GDCR_RESP_OKAY : `GDCR_RESP_SLVERR;
         end else begin
            aw_got_q <= aw_got_q | aw_hs;
            w_got_q  <= w_got_q | w_hs;
            if (bvalid_q & S_AXI_BREADY_IN) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Register bank.

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         pin_setup_q <= `GDCR_RST_PIN_SETUP;
         path_ctrl_q <= `GDCR_RST_PATH_CTRL;
      end else begin
         if (do_w & w_pin & ws0) begin
            // The reserved bit zero stays at zero.
            pin_setup_q <= {wd[7:1], 1'b0};
         end
         // A bus write beats a forward-channel load in the same cycle, so that
         // software setting the override is never undone by a late load.
         if (do_w & w_path & ws0) begin
            path_ctrl_q <= wd;
         end else if (fc_load_evt & ~path_ctrl_q[`GDCR_BIT_KEEP_LOCAL]) begin
            path_ctrl_q <= {1'b0, fc_val_s_q};
         end
      end
   end

   wire ar_hs = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `GDCR_RESP_OKAY;
         rdata_q  <= 8'h00;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         if (S_AXI_ARADDR_IN[1:0] != 2'b00) begin
            rresp_q <= `GDCR_RESP_SLVERR;
            rdata_q <= 8'h00;
         end else if ({2'b00, S_AXI_ARADDR_IN[7:2]} == `GDCR_ADDR_PIN_SETUP) begin
            rresp_q <= `GDCR_RESP_OKAY;
            rdata_q <= pin_setup_q;
         end else if ({2'b00, S_AXI_ARADDR_IN[7:2]} == `GDCR_ADDR_PATH_CTRL) begin
            rresp_q <= `GDCR_RESP_OKAY;
            rdata_q <= path_ctrl_q;
         end else begin
            rresp_q <= `GDCR_RESP_SLVERR;
            rdata_q <= 8'h00;
         end
      end else if (rvalid_q & S_AXI_RREADY_IN) begin
         rvalid_q <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers.

   gdcr_pin_ctrl u_pin8 (
      .local_value_in  (pin_setup_q[`GDCR_BIT_P8_VALUE]),
      .far_drive_in    (pin_setup_q[`GDCR_BIT_P8_FAR]),
      .direction_in    (pin_setup_q[`GDCR_BIT_P8_DIR]),
      .enable_in       (pin_setup_q[`GDCR_BIT_P8_EN]),
      .remote_value_in (far_s_q[1]),
      .func_value_in   (FUNC_PIN8_VALUE_IN),
      .func_oe_in      (FUNC_PIN8_OE_IN),
      .pin_o_out       (PIN8_OUT),
      .pin_oe_out      (PIN8_OE_OUT),
      .mode_out        ()
   );

   gdcr_pin_ctrl u_pin7 (
      .local_value_in  (pin_setup_q[`GDCR_BIT_P7_VALUE]),
      .far_drive_in    (pin_setup_q[`GDCR_BIT_P7_FAR]),
      .direction_in    (pin_setup_q[`GDCR_BIT_P7_DIR]),
      .enable_in       (1'b0),
      .remote_value_in (far_s_q[0]),
      .func_value_in   (FUNC_PIN7_VALUE_IN),
      .func_oe_in      (FUNC_PIN7_OE_IN),
      .pin_o_out       (PIN7_OUT),
      .pin_oe_out      (PIN7_OE_OUT),
      .mode_out        ()
   );

   assign PIN7_SAMPLE_OUT = pin_s_q[0];
   assign PIN8_SAMPLE_OUT = pin_s_q[1];

////////////////////////////////////////////////////////////////////////////////
// Datapath controls.

   wire passthru = path_ctrl_q[`GDCR_BIT_PASSTHRU];
   wire lv_act   = lv_s_q ^ path_ctrl_q[`GDCR_BIT_LV_POL];

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PIXEL_ENABLE_OUT <= 1'b0;
      end else begin
         PIXEL_ENABLE_OUT <= passthru | lv_act;
      end
   end

   assign CONTENT_PROT_ENABLE_OUT = ~passthru;
   assign AUDIO_ON_VIDEO_OUT = ~path_ctrl_q[`GDCR_BIT_AUD_BLOCK] & ~passthru;
   // Four channels only when the override lets bit zero through.
   assign QUAD_AUDIO_OUT = path_ctrl_q[`GDCR_BIT_QUAD_OVR]
                         & path_ctrl_q[`GDCR_BIT_QUAD_EN];
   assign DEPTH_18BIT_OUT  = path_ctrl_q[`GDCR_BIT_DEPTH18];
   assign INBAND_AUDIO_OUT = path_ctrl_q[`GDCR_BIT_INBAND];

endmodule

// File: tb/gdcr_top_properties.sv
// Bus and decode properties for the pin and datapath register bank.
// Assumes it is bound onto gdcr_top and sees only that module's ports.
`timescale 1ns/10ps
module gdcr_props (
   input wire        CORE_CLK_IN,
   input wire        NRST_IN,
   input wire        S_AXI_AWVALID_IN,
   input wire        S_AXI_AWREADY_OUT,
   input wire        S_AXI_WVALID_IN,
   input wire        S_AXI_WREADY_OUT,
   input wire [1:0]  S_AXI_BRESP_OUT,
   input wire        S_AXI_BVALID_OUT,
   input wire        S_AXI_BREADY_IN,
   input wire        S_AXI_ARVALID_IN,
   input wire        S_AXI_ARREADY_OUT,
   input wire [31:0] S_AXI_RDATA_OUT,
   input wire        S_AXI_RVALID_OUT,
   input wire        S_AXI_RREADY_IN,
   input wire        PIXEL_ENABLE_OUT,
   input wire        CONTENT_PROT_ENABLE_OUT,
   input wire        AUDIO_ON_VIDEO_OUT,
   input wire        QUAD_AUDIO_OUT,
   input wire        DEPTH_18BIT_OUT,
   input wire        INBAND_AUDIO_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   ////////////////////////////////////////////////////////////
   sequence wr_taken;
      S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   endsequence
   sequence rd_taken;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   endsequence
   write_answer_a: assert property (wr_taken |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
      else $error("write response missing");
   bresp_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
   read_answer_a: assert property (rd_taken |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
      else $error("read response missing");
   rdata_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
   rdata_width_a: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h0)
      else $error("read data above byte");
   passthru_audio_a: assert property (!CONTENT_PROT_ENABLE_OUT |-> !AUDIO_ON_VIDEO_OUT)
      else $error("audio left on in passthrough");
   passthru_pixel_a: assert property (!CONTENT_PROT_ENABLE_OUT |=> PIXEL_ENABLE_OUT)
      else $error("passthrough pixels gated");
   reset_state_a: assert property ($rose(NRST_IN) |-> CONTENT_PROT_ENABLE_OUT &&
      AUDIO_ON_VIDEO_OUT && !QUAD_AUDIO_OUT && !DEPTH_18BIT_OUT && !INBAND_AUDIO_OUT)
      else $error("path outputs not cleared by reset");
endmodule
bind gdcr_top gdcr_props u_props (.CORE_CLK_IN, .NRST_IN, .S_AXI_AWVALID_IN,
   .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT,
   .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
   .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .PIXEL_ENABLE_OUT,
   .CONTENT_PROT_ENABLE_OUT, .AUDIO_ON_VIDEO_OUT, .QUAD_AUDIO_OUT, .DEPTH_18BIT_OUT,
   .INBAND_AUDIO_OUT);

// File: tb/gdcr_far_model.sv
// Far-end serializer: forward-channel path loads and remote pin values.
// Assumes the caller enters send just after a rising clock edge.
`timescale 1ns/10ps
module gdcr_far_model (
   input  wire       clk_in,
   output reg        load_out,
   output reg  [6:0] path_out,
   output reg        far7_out,
   output reg        far8_out
);
   initial begin
      load_out = 1'b0;
      path_out = 7'h55;
      far7_out = 1'b1;
      far8_out = 1'b0;
   end
   // The value is held well past the load edge, then inverted so a late sample shows.
   task send(input [6:0] v);
      begin
         @(posedge clk_in);
         path_out <= v;
         @(posedge clk_in);
         load_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         load_out <= 1'b0;
         repeat (2) @(posedge clk_in);
         path_out <= ~v;
      end
   endtask
   task set_far(input a7, input a8);
      begin
         @(posedge clk_in);
         far7_out <= a7;
         far8_out <= a8;
      end
   endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the pin and datapath register bank.
// Assumes gdcr_top, the far-end model and the property checker compile alongside.
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [5:0] e;} gdcr_row_t;
   reg         clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   reg         rready = 0, lv = 0, f7v = 0, pin7 = 0, pin8 = 0;
   reg         f7oe = 1, f8v = 1, f8oe = 1;
   // A non-zero count keeps the response ready low that long, so held answers are seen.
   int         slow = 0;
   reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg  [31:0] wdata = 32'h0;
   reg  [3:0]  wstrb = 4'hf;
   wire [31:0] rdata;
   wire [1:0]  bresp, rresp;
   wire [6:0]  fv;
   wire        awrdy, wrdy, bvalid, arrdy, rvalid, fl, far7, far8, p7, p7oe, p8, p8oe;
   wire        s7, s8, pix, cp, aov, quad, d18, inb;
   int         errors = 0, total_checks = 0;
   logic [31:0] d;
   logic [1:0] r;
   logic [5:0] o;
   gdcr_row_t  rows [14] = '{'{8'h84,8'h00,6'h0e}, '{8'h84,8'h10,6'h0a},
      '{8'h84,8'h98,6'h0e}, '{8'h84,8'h33,6'h00}, '{8'h84,8'h20,6'h02},
      '{8'h84,8'h74,6'h0b}, '{8'h84,8'hc0,6'h0a}, '{8'h88,8'h0f,6'h3e},
      '{8'h88,8'h07,6'h36}, '{8'h88,8'h09,6'h38}, '{8'h88,8'h10,6'h20},
      '{8'h88,8'h40,6'h01}, '{8'h88,8'h20,6'h31}, '{8'h88,8'h00,6'h30}};
   always #20 clk = ~clk;
   gdcr_far_model u_far (.clk_in(clk), .load_out(fl), .path_out(fv), .far7_out(far7),
      .far8_out(far8));
   gdcr_top u_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wrdy),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arrdy),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .FC_LOAD_IN(fl), .FC_PATH_VALUE_IN(fv),
      .FAR_PIN7_VALUE_IN(far7), .FAR_PIN8_VALUE_IN(far8), .FUNC_PIN7_VALUE_IN(f7v),
      .FUNC_PIN7_OE_IN(f7oe), .FUNC_PIN8_VALUE_IN(f8v), .FUNC_PIN8_OE_IN(f8oe),
      .PIN7_IN(pin7), .PIN8_IN(pin8), .LINE_VALID_STROBE_IN(lv), .PIN7_OUT(p7),
      .PIN7_OE_OUT(p7oe), .PIN8_OUT(p8), .PIN8_OE_OUT(p8oe), .PIN7_SAMPLE_OUT(s7),
      .PIN8_SAMPLE_OUT(s8), .PIXEL_ENABLE_OUT(pix), .CONTENT_PROT_ENABLE_OUT(cp),
      .AUDIO_ON_VIDEO_OUT(aov), .QUAD_AUDIO_OUT(quad), .DEPTH_18BIT_OUT(d18),
      .INBAND_AUDIO_OUT(inb));
   ////////////////////////////////////////////////////////////
   task end_of_test;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      begin
         total_checks++;
         if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   // Ready is looked at on the falling edge, where it is settled, and acted on at the next rise.
   task wr(input [7:0] a, input [7:0] v, output [1:0] rs);
      reg ta, tw, tb;
      begin
         tb = 0;
         awaddr <= a;
         wdata <= {24'h0, v};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= (slow == 0);
         for (int n = 0; n < 50 && !tb; n++) begin
            @(negedge clk);
            ta = awvalid & awrdy;
            tw = wvalid & wrdy;
            tb = bvalid & bready;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            else if (n + 1 >= slow) bready <= 1'b1;
         end
         if (!tb) begin
            errors++;
            end_of_test;
         end
         @(posedge clk);
      end
   endtask
   task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
      reg ta, tr;
      begin
         tr = 0;
         araddr <= a;
         arvalid <= 1'b1;
         rready <= (slow == 0);
         for (int n = 0; n < 50 && !tr; n++) begin
            @(negedge clk);
            ta = arvalid & arrdy;
            tr = rvalid & rready;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            else if (n + 1 >= slow) rready <= 1'b1;
         end
         if (!tr) begin
            errors++;
            end_of_test;
         end
         @(posedge clk);
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h84, d, r);
      chk("pin setup reset", 32'h0, d);
      rd(8'h88, d, r);
      chk("path reset", 32'h0, d);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r);
         chk("write resp", 2'b00, r);
         repeat (4) @(posedge clk);
         rd(rows[i].a, d, r);
         chk("readback", {24'h0, rows[i].d & (rows[i].a[2] ? 8'hfe : 8'hff)}, d);
         o = rows[i].a[2] ? {2'b00, p8oe, p8 & p8oe, p7oe, p7 & p7oe}
                          : {cp, aov, quad, d18, inb, pix};
         chk("outputs", rows[i].e, o);
      end
      wr(8'h88, 8'h00, r);
      u_far.send(7'h45);
      rd(8'h88, d, r);
      chk("forward load", 32'h45, d);
      wr(8'h88, 8'h80, r);
      u_far.send(7'h2a);
      rd(8'h88, d, r);
      chk("override load", 32'h80, d);
      wr(8'h8c, 8'hff, r);
      chk("unmapped write", 2'b10, r);
      rd(8'h8c, d, r);
      chk("unmapped read", 32'h0, d);
      chk("unmapped read resp", 32'h2, {30'h0, r});
      wr(8'h85, 8'hff, r);
      chk("unaligned write", 2'b10, r);
      wstrb <= 4'h0;
      wr(8'h84, 8'hff, r);
      chk("masked write resp", 2'b00, r);
      wstrb <= 4'hf;
      rd(8'h84, d, r);
      chk("pin setup kept", 32'hc0, d);
      wr(8'h88, 8'h00, r);
      lv <= 1'b1;
      pin7 <= 1'b1;
      f7v <= 1'b1;
      repeat (4) @(posedge clk);
      chk("pixel high strobe", 1'b1, pix);
      chk("pad samples", 3'b011, {s8, s7, p7});
      wr(8'h88, 8'h20, r);
      repeat (4) @(posedge clk);
      chk("pixel inverted", 1'b0, pix);
      wr(8'h84, 8'h44, r);
      u_far.set_far(1'b0, 1'b1);
      repeat (4) @(posedge clk);
      chk("remote pads", 4'he, {p8oe, p8, p7oe, p7});
      // Slow ready keeps both answers waiting, so the hold properties are exercised.
      slow = 4;
      wr(8'h88, 8'h06, r);
      chk("slow write resp", 2'b00, r);
      rd(8'h88, d, r);
      slow = 0;
      chk("slow readback", 32'h06, d);
      chk("depth transport", 3'b011, {quad, d18, inb});
      // Reset in mid-run must clear both registers and hand the pads back to functional drive.
      nrst <= 1'b0;
      f8v <= 1'b0;
      f7oe <= 1'b0;
      pin8 <= 1'b1;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h84, d, r);
      chk("pin setup re-reset", 32'h0, d);
      rd(8'h88, d, r);
      chk("path re-reset", 32'h0, d);
      chk("functional pads", 4'h9, {p8oe, p8, p7oe, p7});
      chk("pin8 sample", 1'b1, s8);
      end_of_test;
   end
endmodule
